// ### src/flash_ctrl_pkg.sv
/*
 * Shared constants and carrier types for the flash user-mode controller.
 * Assumes a 125 MHz system clock and byte-wide code-space accesses.
 */
package flash_ctrl_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int SECTOR_BYTES = 128;
	localparam int SECTORS_LARGE = 64;
	localparam int SECTORS_SMALL = 32;
	localparam int SECTOR_OFS_W = 7;
	localparam int ADDR_W = 13;

	// ****************************************
	// Register values and fields
	// ****************************************
	localparam logic [7:0] UNLOCK_KEY_RST = 8'h00;
	localparam logic [7:0] UNLOCK_KEY_OPEN = 8'ha5;
	localparam logic [7:0] OP_CONTROL_RST = 8'h00;
	localparam int START_BIT_POS = 0;
	localparam logic [6:0] MODE_ERASE = 7'h50;
	localparam logic [6:0] MODE_PROGRAM = 7'h28;
	localparam logic [6:0] MODE_HARD_LOCK = 7'h33;
	localparam logic [7:0] PROTECTED_READ = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 125;
	localparam int ERASE_TIME_US = 8000;
	localparam int PROGRAM_TIME_US = 25;
	localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
	localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} reg_write_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} code_access_t;

endpackage

// ### src/flash_array.sv
/*
 * Byte-wide flash array model with a registered read port and a
 * whole-sector fill port. Assumes the controller sequences all access.
 */
`timescale 1ns/1ps

module flash_array #(
	parameter int ADDR_W = 13,
	parameter int OFS_W = 7
) (
	input wire logic clk_sys_i,
	input wire logic rd_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	input wire logic wr_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic erase_i,
	input wire logic [ADDR_W-1:0] erase_addr_i
);

	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-OFS_W-1:0] erase_sector;

	assign erase_sector = erase_addr_i[ADDR_W-1:OFS_W];

	always_ff @(posedge clk_sys_i) begin
		if (rd_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end

	// Erase clears one sector in a single edge; programming only pulls
	// bits low, like real cells do.
	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < (1 << OFS_W); i++) begin
			if (erase_i) begin
				mem[{erase_sector, i[OFS_W-1:0]}] <= flash_ctrl_pkg::ERASED_BYTE;
			end
		end
		if (wr_i && !erase_i) begin
			mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
		end
	end

endmodule // flash_array

// ### src/flash_user_mode_controller.sv
/*
 * Flash user-mode controller: unlock key, sector address, operation
 * control, erase and program timing, CPU stall and protections.
 * Assumes the CPU holds code-space requests while stall_o is high.
 */
// Contract
// [R1] 64 or 32 sectors of 128 bytes
// [R2] Erase by sector, program by byte
// [R3] Erase at least 8 ms, program 25 us
// [R4] Tool mode holds other modules in reset
// [R5] Tool mode offers chip erase only
// [R6] Read protection reads return 00
// [R7] Tool chip erase removes read protection
// [R8] Control register only works when unlocked
// [R9] Start bit launches erase and hard lock
// [R10] CPU halted during erase, then resumes
// [R11] Read and program ignore start bit
// [R12] Unlock key resets to zero
// [R13] Only key a5 unlocks user mode
// [R14] Sector base ignores low seven bits
// [R15] Software loads sector before each write
// [R16] Erase sequence key, address, control, relock
// [R17] Erase needs start rising edge while unlocked
// [R18] Start bit clears after erase completes
// [R19] Locked start leaves start bit set
// [R20] Program byte by code-space store
// [R21] Program mode ignores start bit
// [R22] Read byte by code-space load
// [R23] Stall CPU during byte program
// [R24] Out-of-sector or locked writes ignored
// [R25] Hard lock blocks later erase, program
`timescale 1ns/1ps

module flash_user_mode_controller #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter int ERASE_CYCLES = flash_ctrl_pkg::ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = flash_ctrl_pkg::PROGRAM_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire flash_ctrl_pkg::reg_write_t unlock_key_wr_i,
	input wire flash_ctrl_pkg::reg_write_t sector_addr_high_wr_i,
	input wire flash_ctrl_pkg::reg_write_t sector_addr_low_wr_i,
	input wire flash_ctrl_pkg::reg_write_t flash_op_control_wr_i,
	input wire flash_ctrl_pkg::code_access_t code_space_load_store_i,
	input wire logic tool_mode_i,
	input wire logic tool_chip_erase_i,
	input wire logic tool_read_protect_i,
	output logic [7:0] flash_unlock_key_o,
	output logic [7:0] sector_addr_high_o,
	output logic [7:0] sector_addr_low_o,
	output logic [7:0] flash_op_control_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic stall_o,
	output logic busy_o,
	output logic hard_locked_o,
	output logic read_protected_o,
	output logic periph_reset_n_o
);

	localparam int AW = flash_ctrl_pkg::ADDR_W;
	localparam int OW = flash_ctrl_pkg::SECTOR_OFS_W;
	localparam int SECTORS = LARGE_VARIANT ? flash_ctrl_pkg::SECTORS_LARGE
		: flash_ctrl_pkg::SECTORS_SMALL;
	localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
	localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);
	localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROGRAM_CYCLES - 1);

	typedef enum logic [2:0] {
		ST_IDLE, ST_ERASE, ST_PROGRAM, ST_CHIP_ERASE, ST_CHIP_FILL
	} state_t;

	// ****************************************
	// Registers
	// ****************************************
	state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [7:0] key_reg, sec_hi_reg, sec_lo_reg, ctl_reg;
	logic hard_lock_reg, read_prot_reg;
	logic tool_meta_reg, tool_sync_reg;
	logic cerase_meta_reg, cerase_sync_reg, cerase_old_reg;
	logic rprot_meta_reg, rprot_sync_reg;
	logic [AW-1:0] prog_addr_reg;
	logic [7:0] prog_data_reg;
	logic [AW-OW-1:0] fill_sector_reg;
	logic rd_pend_reg;
	logic [7:0] array_rd_data;

	// ****************************************
	// Decode
	// ****************************************
	wire unlocked;
	wire [6:0] op_mode;
	wire start_rise;
	wire launch_erase;
	wire launch_lock;
	wire store_ok;
	wire [AW-1:0] sector_base;
	wire [AW-1:0] fill_base;
	wire cerase_rise;
	wire idle;
	wire [7:0] ctl_wdata;

	// [R12] [R13] Only a5 unlocks
	assign unlocked = key_reg == flash_ctrl_pkg::UNLOCK_KEY_OPEN
		&& !tool_sync_reg;
	assign idle = state_reg == ST_IDLE;
	assign ctl_wdata = flash_op_control_wr_i.data;
	assign op_mode = ctl_reg[7:1];
	// [R17] Rising start edge; unlock is checked at launch, not here
	assign start_rise = flash_op_control_wr_i.wr
		&& ctl_wdata[flash_ctrl_pkg::START_BIT_POS]
		&& !ctl_reg[flash_ctrl_pkg::START_BIT_POS];
	// [R8] [R9] Start acts on selected mode
	assign launch_erase = start_rise && unlocked && idle && !hard_lock_reg
		&& ctl_wdata[7:1] == flash_ctrl_pkg::MODE_ERASE;
	assign launch_lock = start_rise && unlocked && idle
		&& ctl_wdata[7:1] == flash_ctrl_pkg::MODE_HARD_LOCK;
	// [R14] Low seven bits ignored
	assign sector_base = {sec_hi_reg[AW-9:0], sec_lo_reg[7], {OW{1'b0}}};
	// [R20] [R21] [R24] Store programs only in named sector
	assign store_ok = code_space_load_store_i.wr && unlocked && idle
		&& !hard_lock_reg && op_mode == flash_ctrl_pkg::MODE_PROGRAM
		&& code_space_load_store_i.addr[AW-1:OW] == sector_base[AW-1:OW]
		&& 32'(code_space_load_store_i.addr[AW-1:OW]) < SECTORS;
	// [R5] Tool chip erase only
	assign cerase_rise = cerase_sync_reg && !cerase_old_reg && tool_sync_reg;
	assign fill_base = {fill_sector_reg, {OW{1'b0}}};

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		tool_meta_reg <= tool_mode_i;
		tool_sync_reg <= tool_meta_reg;
		cerase_meta_reg <= tool_chip_erase_i;
		cerase_sync_reg <= cerase_meta_reg;
		// Edge memory follows the synced pin, so no false edge after reset
		cerase_old_reg <= cerase_sync_reg;
		rprot_meta_reg <= tool_read_protect_i;
		rprot_sync_reg <= rprot_meta_reg;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			ST_IDLE: begin
				cnt_next = '0;
				if (cerase_rise) begin
					state_next = ST_CHIP_FILL;
				end else if (launch_erase) begin
					state_next = ST_ERASE;
				end else if (store_ok) begin
					state_next = ST_PROGRAM;
				end
			end
			// [R3] [R10] Erase timed, CPU held
			ST_ERASE: begin
				cnt_next = cnt_reg + CNT_W'(1);
				if (cnt_reg == ERASE_LAST) begin
					state_next = ST_IDLE;
				end
			end
			// [R3] [R23] Program timed, CPU held
			ST_PROGRAM: begin
				cnt_next = cnt_reg + CNT_W'(1);
				if (cnt_reg == PROG_LAST) begin
					state_next = ST_IDLE;
				end
			end
			ST_CHIP_FILL: begin
				if (32'(fill_sector_reg) == SECTORS - 1) begin
					state_next = ST_CHIP_ERASE;
				end
			end
			ST_CHIP_ERASE: begin
				cnt_next = cnt_reg + CNT_W'(1);
				if (cnt_reg == ERASE_LAST) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			fill_sector_reg <= '0;
		end else if (state_reg == ST_CHIP_FILL) begin
			fill_sector_reg <= fill_sector_reg + 1'b1;
		end else begin
			fill_sector_reg <= '0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (store_ok) begin
			prog_addr_reg <= code_space_load_store_i.addr;
			prog_data_reg <= code_space_load_store_i.wdata;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			// [R12] Key cleared by reset
			key_reg <= flash_ctrl_pkg::UNLOCK_KEY_RST;
			sec_hi_reg <= 8'h00;
			sec_lo_reg <= 8'h00;
		end else begin
			if (unlock_key_wr_i.wr) begin
				key_reg <= unlock_key_wr_i.data;
			end
			if (sector_addr_high_wr_i.wr) begin
				sec_hi_reg <= sector_addr_high_wr_i.data;
			end
			if (sector_addr_low_wr_i.wr) begin
				sec_lo_reg <= sector_addr_low_wr_i.data;
			end
		end
	end

	// [R18] [R19] Start clears after launched erase, or on the hard-lock launch write
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctl_reg <= flash_ctrl_pkg::OP_CONTROL_RST;
		end else if (flash_op_control_wr_i.wr) begin
			ctl_reg <= launch_lock ? {ctl_wdata[7:1], 1'b0} : ctl_wdata;
		end else if (state_reg == ST_ERASE && cnt_reg == ERASE_LAST) begin
			ctl_reg[flash_ctrl_pkg::START_BIT_POS] <= 1'b0;
		end
	end

	// [R25] [R6] [R7] Protection state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hard_lock_reg <= 1'b0;
			read_prot_reg <= 1'b0;
		end else begin
			if (launch_lock) begin
				hard_lock_reg <= 1'b1;
			end else if (cerase_rise) begin
				hard_lock_reg <= 1'b0;
			end
			if (tool_sync_reg && rprot_sync_reg) begin
				read_prot_reg <= 1'b1;
			end else if (cerase_rise) begin
				read_prot_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Array and read path
	// ****************************************
	// [R1] [R2] Sector erase or byte write
	flash_array #(
		.ADDR_W(AW),
		.OFS_W(OW)
	) u_array (
		.clk_sys_i(clk_sys_i),
		.rd_i(code_space_load_store_i.rd && idle),
		.rd_addr_i(code_space_load_store_i.addr),
		.rd_data_o(array_rd_data),
		.wr_i(state_reg == ST_PROGRAM && cnt_reg == PROG_LAST),
		.wr_addr_i(prog_addr_reg),
		.wr_data_i(prog_data_reg),
		.erase_i(launch_erase || state_reg == ST_CHIP_FILL),
		.erase_addr_i(state_reg == ST_CHIP_FILL ? fill_base : sector_base)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_pend_reg <= 1'b0;
		end else begin
			// [R11] [R22] Load reads without start bit
			rd_pend_reg <= code_space_load_store_i.rd && idle;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flash_unlock_key_o <= 8'h00;
			sector_addr_high_o <= 8'h00;
			sector_addr_low_o <= 8'h00;
			flash_op_control_o <= 8'h00;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			stall_o <= 1'b0;
			busy_o <= 1'b0;
			hard_locked_o <= 1'b0;
			read_protected_o <= 1'b0;
			periph_reset_n_o <= 1'b0;
		end else begin
			flash_unlock_key_o <= key_reg;
			sector_addr_high_o <= sec_hi_reg;
			sector_addr_low_o <= sec_lo_reg;
			flash_op_control_o <= ctl_reg;
			// [R6] Protected reads return zero
			rd_data_o <= read_prot_reg ? flash_ctrl_pkg::PROTECTED_READ
				: array_rd_data;
			rd_valid_o <= rd_pend_reg;
			// [R10] [R23] Stall follows busy state
			stall_o <= state_next != ST_IDLE;
			busy_o <= state_next != ST_IDLE;
			hard_locked_o <= hard_lock_reg;
			read_protected_o <= read_prot_reg;
			// [R4] Other modules reset in tool mode
			periph_reset_n_o <= !tool_sync_reg;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_erase_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		launch_erase |=> (state_reg == ST_ERASE) [*8];
	endproperty
	a_erase_len: assert property (p_erase_len) // [R3]
		else $error("erase ended too early");

	property p_stall_erase;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		launch_erase |=> ##1 stall_o;
	endproperty
	a_stall_erase: assert property (p_stall_erase) // [R10]
		else $error("cpu not stalled during erase");

	property p_locked_start;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		start_rise && !unlocked |=> ctl_reg[0] && state_reg == ST_IDLE;
	endproperty
	a_locked_start: assert property (p_locked_start) // [R19]
		else $error("locked start not held");

	property p_erase_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg == ST_ERASE && cnt_reg == ERASE_LAST
		&& !flash_op_control_wr_i.wr |=> !ctl_reg[0];
	endproperty
	a_erase_clear: assert property (p_erase_clear) // [R18]
		else $error("start bit not cleared");

	property p_key_gate;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		key_reg != 8'ha5 |-> !launch_erase && !store_ok;
	endproperty
	a_key_gate: assert property (p_key_gate) // [R13]
		else $error("operation while locked");

	property p_prog_stall;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		store_ok |=> state_reg == ST_PROGRAM ##1 stall_o;
	endproperty
	a_prog_stall: assert property (p_prog_stall) // [R23]
		else $error("program did not stall");

	property p_protect_read;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rd_pend_reg && read_prot_reg |=> rd_data_o == 8'h00;
	endproperty
	a_protect_read: assert property (p_protect_read) // [R6]
		else $error("protected read leaked");

	property p_hard_lock;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		hard_lock_reg |-> !launch_erase && !store_ok;
	endproperty
	a_hard_lock: assert property (p_hard_lock) // [R25]
		else $error("operation under hard lock");

	property p_tool_reset;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		tool_sync_reg |=> !periph_reset_n_o;
	endproperty
	a_tool_reset: assert property (p_tool_reset) // [R4]
		else $error("peripherals not reset");

endmodule // flash_user_mode_controller

// ### verification/cpu_model.sv
/*
 * Behavioural CPU issuing code-space loads and stores.
 * Assumes the controller stalls requests through stall_i.
 */
`timescale 1ns/1ps

module cpu_model (
	input wire logic clk_sys_i,
	input wire logic stall_i,
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_data_i,
	output flash_ctrl_pkg::code_access_t acc_o
);
	initial acc_o = '0;

	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic issue(input logic rd, input logic [12:0] a,
		input logic [7:0] v);
		int i;
		for (i = 0; i < 5000 && stall_i !== 1'b0; i++) @(negedge clk_sys_i);
		acc_o = '{rd: rd, wr: !rd, addr: a, wdata: v};
		@(negedge clk_sys_i);
		// Released bus does not keep its last value
		acc_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
	endtask

	task automatic store(input logic [12:0] a, input logic [7:0] v,
		output int n);
		int i;
		issue(1'b0, a, v);
		n = 0;
		for (i = 0; i < 8 && stall_i !== 1'b1; i++) @(negedge clk_sys_i);
		while (stall_i === 1'b1 && n < 5000) begin
			n++;
			@(negedge clk_sys_i);
		end
	endtask

	task automatic load(input logic [12:0] a, output logic [7:0] d);
		int i;
		issue(1'b1, a, 8'h00);
		for (i = 0; i < 8 && rd_valid_i !== 1'b1; i++) @(negedge clk_sys_i);
		d = rd_valid_i ? rd_data_i : 8'hxx;
	endtask
endmodule // cpu_model

// ### verification/tb_top.sv
/*
 * Self-checking bench for the flash user-mode controller.
 * Assumes shortened erase and program counts.
 */
`timescale 1ns/1ps
`define check(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
	err_total++; $display("mismatch at %0t: got %h expected %h", \
	$time, act, exp); end end

module tb_top;
	localparam int ERASE_N = 20;
	localparam int PROG_N = 10;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	flash_ctrl_pkg::reg_write_t wr_req [4] = '{default: '0};
	flash_ctrl_pkg::code_access_t acc;
	logic tool_mode = 1'b0, tool_erase = 1'b0, tool_prot = 1'b0;
	logic [7:0] key_o, hi_o, lo_o, ctl_o, rd_data, d;
	logic rd_valid, stall, busy, hard_locked, read_prot, periph_rst_n;
	int err_total = 0, cmp_count = 0, n, i;

	initial forever #4 clk_sys_i = ~clk_sys_i;

	flash_user_mode_controller #(.ERASE_CYCLES(ERASE_N),
		.PROGRAM_CYCLES(PROG_N)) dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.unlock_key_wr_i(wr_req[0]), .sector_addr_high_wr_i(wr_req[1]),
		.sector_addr_low_wr_i(wr_req[2]), .flash_op_control_wr_i(wr_req[3]),
		.code_space_load_store_i(acc), .tool_mode_i(tool_mode),
		.tool_chip_erase_i(tool_erase), .tool_read_protect_i(tool_prot),
		.flash_unlock_key_o(key_o), .sector_addr_high_o(hi_o),
		.sector_addr_low_o(lo_o), .flash_op_control_o(ctl_o),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .stall_o(stall),
		.busy_o(busy), .hard_locked_o(hard_locked),
		.read_protected_o(read_prot), .periph_reset_n_o(periph_rst_n));

	cpu_model u_cpu (.clk_sys_i(clk_sys_i), .stall_i(stall),
		.rd_valid_i(rd_valid), .rd_data_i(rd_data), .acc_o(acc));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic wreg(input int sel, input logic [7:0] v);
		@(negedge clk_sys_i);
		wr_req[sel] = '{wr: 1'b1, data: v};
		@(negedge clk_sys_i);
		wr_req[sel].wr = 1'b0;
	endtask

	task automatic wait_cyc(input int c);
		repeat (c) @(negedge clk_sys_i);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		err_total++;
		results;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		wait_cyc(16);
		rst_n_i = 1'b1;
		wait_cyc(2);
		`check(key_o, 8'h00)
		`check(ctl_o, 8'h00)
		`check(periph_rst_n, 1'b1)
		wreg(3, 8'ha1);
		wait_cyc(4);
		`check(stall, 1'b0)
		`check(ctl_o, 8'ha1)
		wreg(3, 8'h00);
		wreg(0, 8'ha5);
		wreg(1, 8'h04);
		wreg(2, 8'h7f);
		wreg(3, 8'ha1);
		`check(busy, 1'b1)
		n = 0;
		while (stall === 1'b1 && n < 5000) begin
			n++;
			@(negedge clk_sys_i);
		end
		`check(n >= ERASE_N - 2 && n <= ERASE_N + 2, 1'b1)
		wait_cyc(1);
		`check(ctl_o, 8'ha0)
		`check(hi_o, 8'h04)
		`check(lo_o, 8'h7f)
		wreg(0, 8'h00);
		u_cpu.load(13'h0410, d);
		`check(d, flash_ctrl_pkg::ERASED_BYTE)
		u_cpu.load(13'h047f, d);
		`check(d, flash_ctrl_pkg::ERASED_BYTE)
		wreg(0, 8'ha5);
		wreg(3, 8'h50);
		wreg(2, 8'h00);
		u_cpu.store(13'h0410, 8'haa, n);
		`check(n >= PROG_N, 1'b1)
		u_cpu.load(13'h0410, d);
		`check(d, 8'haa)
		wreg(3, 8'h51);
		u_cpu.store(13'h0411, 8'h55, n);
		u_cpu.load(13'h0411, d);
		`check(d, 8'h55)
		wreg(2, 8'h80);
		u_cpu.store(13'h0412, 8'h00, n);
		`check(n, 0)
		u_cpu.load(13'h0412, d);
		`check(d, 8'hff)
		wreg(2, 8'h00);
		wreg(0, 8'ha4);
		u_cpu.store(13'h0413, 8'h00, n);
		u_cpu.load(13'h0413, d);
		`check(d, 8'hff)
		tool_mode = 1'b1;
		wait_cyc(6);
		`check(periph_rst_n, 1'b0)
		wreg(0, 8'ha5);
		wreg(3, 8'h00);
		wreg(3, 8'ha1);
		wait_cyc(6);
		`check(stall, 1'b0)
		tool_prot = 1'b1;
		wait_cyc(6);
		`check(read_prot, 1'b1)
		tool_prot = 1'b0;
		tool_mode = 1'b0;
		wait_cyc(6);
		wreg(3, 8'h00);
		u_cpu.load(13'h0410, d);
		`check(d, flash_ctrl_pkg::PROTECTED_READ)
		tool_mode = 1'b1;
		wait_cyc(4);
		tool_erase = 1'b1;
		n = 0;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk_sys_i);
			if (busy === 1'b1)
				n = 1;
			else if (n == 1)
				break;
		end
		tool_erase = 1'b0;
		`check(read_prot, 1'b0)
		tool_mode = 1'b0;
		wait_cyc(6);
		u_cpu.load(13'h0410, d);
		`check(d, flash_ctrl_pkg::ERASED_BYTE)
		wreg(0, 8'ha5);
		wreg(3, 8'h67);
		wait_cyc(3);
		`check(hard_locked, 1'b1)
		`check(ctl_o, 8'h66)
		wreg(3, 8'h50);
		u_cpu.store(13'h0415, 8'h00, n);
		u_cpu.load(13'h0415, d);
		`check(d, 8'hff)
		results;
	end
endmodule // tb_top
